// file: rtl/eebp_consts.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  byte-programming controller. Assumes inclusion by the package and the core.
*/
`ifndef EEBP_CONSTS_SVH
`define EEBP_CONSTS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define EEBP_OFS_CTRL      12'h000
`define EEBP_OFS_ADDR      12'h004
`define EEBP_OFS_DATA      12'h008
`define EEBP_OFS_IRQ_STAT  12'h00c
`define EEBP_OFS_IRQ_EN    12'h010
`define EEBP_OFS_IRQ_CLR   12'h014

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define EEBP_CTRL_READ_BIT   0
`define EEBP_CTRL_PE_BIT     1
`define EEBP_CTRL_MPE_BIT    2
`define EEBP_CTRL_MODE_LO    4
`define EEBP_CTRL_MODE_HI    5

// ----------------------------------------------------------------------------
// status bits and reset values
// ----------------------------------------------------------------------------
`define EEBP_IRQ_DONE_BIT    0
`define EEBP_IRQ_REFUSE_BIT  1
`define EEBP_ERASED_BYTE     8'hff
`define EEBP_RST_BYTE        8'h00

// ----------------------------------------------------------------------------
// timing counts, in core clock cycles
// ----------------------------------------------------------------------------
`define EEBP_MPE_WINDOW      3'h4
`define EEBP_READ_STALL      3'h4
`define EEBP_PROG_STALL      3'h2
`define EEBP_ERASE_CYC_DEF   16
`define EEBP_WRITE_CYC_DEF   16
`define EEBP_ATOMIC_CYC_DEF  32

`endif

// file: rtl/eebp_pkg.sv
/*
  Types of the byte-programming controller.
  Assumes eebp_consts.svh is on the include path.
*/
`default_nettype none
`include "eebp_consts.svh"

package eebp_pkg;
  // programming mode field encoding
  typedef enum logic [1:0] {
    EEBP_MODE_ATOMIC = 2'h0,
    EEBP_MODE_ERASE  = 2'h1,
    EEBP_MODE_WRITE  = 2'h2,
    EEBP_MODE_RSVD   = 2'h3
  } eebp_mode_t;

  typedef enum logic [1:0] {
    EEBP_OP_NONE,
    EEBP_OP_ATOMIC,
    EEBP_OP_ERASE,
    EEBP_OP_WRITE
  } eebp_op_t;
endpackage : eebp_pkg
`default_nettype wire

// file: rtl/eebp_ctrl.sv
/*
  Byte-access controller for a small on-chip nonvolatile byte array, with an
  APB register slave, a CPU stall output and one level interrupt.
  Assumes a single 250 MHz core clock, zero-wait APB master on that clock.
*/
// Functional notes
// - control registers mapped in CPU register space
// - read stalls CPU four cycles
// - programming start stalls CPU two cycles
// - mode zero: erase then write atomically
// - mode one: erase only
// - mode two: write only, no erase
// - program enable reads set until done
// - no other access while programming
`timescale 1ns/100ps
`default_nettype none
`include "eebp_consts.svh"

module eebp_ctrl #(
  parameter int ADDR_W     = 7,
  parameter int ERASE_CYC  = `EEBP_ERASE_CYC_DEF,
  parameter int WRITE_CYC  = `EEBP_WRITE_CYC_DEF,
  parameter int ATOMIC_CYC = `EEBP_ATOMIC_CYC_DEF
) (
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             cpu_stall_o,
  output logic             busy_o,
  output logic             irq_o
);
  import eebp_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;
  localparam int CNT_W = 16;

  // refused at elaboration: the counters and the array index cannot serve these
  if (ADDR_W < 1 || ADDR_W > 8)
  begin : g_bad_addr_w
    $error("ADDR_W must lie in 1..8");
  end
  if (ERASE_CYC < 1 || WRITE_CYC < 1 || ATOMIC_CYC < 1)
  begin : g_bad_dur_low
    $error("programming durations must be at least one cycle");
  end
  if (ERASE_CYC >= 65536 || WRITE_CYC >= 65536 || ATOMIC_CYC >= 65536)
  begin : g_bad_dur_high
    $error("programming durations must fit 16 bits");
  end

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  logic wr_acc;
  logic hit;
  logic wr_ctrl;
  logic wr_addr;
  logic wr_data;
  logic wr_en;
  logic wr_clr;

  // every register answers at once; no wait states
  assign pready_o = 1'b1;
  assign wr_acc   = psel_i && penable_i && pwrite_i;

  always_comb
  begin
    case (paddr_i)
      `EEBP_OFS_CTRL, `EEBP_OFS_ADDR, `EEBP_OFS_DATA,
      `EEBP_OFS_IRQ_STAT, `EEBP_OFS_IRQ_EN, `EEBP_OFS_IRQ_CLR: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  assign pslverr_o = psel_i && penable_i && !hit;
  // byte lane 0 carries every field, so only it is honoured
  assign wr_ctrl = wr_acc && pstrb_i[0] && (paddr_i == `EEBP_OFS_CTRL);
  assign wr_addr = wr_acc && pstrb_i[0] && (paddr_i == `EEBP_OFS_ADDR);
  assign wr_data = wr_acc && pstrb_i[0] && (paddr_i == `EEBP_OFS_DATA);
  assign wr_en   = wr_acc && pstrb_i[0] && (paddr_i == `EEBP_OFS_IRQ_EN);
  assign wr_clr  = wr_acc && pstrb_i[0] && (paddr_i == `EEBP_OFS_IRQ_CLR);

  // --------------------------------------------------------------------------
  // software-loaded address, byte value and mode
  // --------------------------------------------------------------------------
  logic [ADDR_W-1:0] nvm_addr_reg_q;
  logic [7:0]        nvm_byte_value_reg_q;
  logic [1:0]        program_mode_field_q;
  logic [7:0]        mem_q [DEPTH];
  logic [CNT_W-1:0]  busy_cnt_q;
  logic [2:0]        stall_cnt_q;
  logic [2:0]        mpe_cnt_q;
  logic              busy;
  logic              idle;
  logic              rd_go;
  logic              pe_req;
  logic              prog_go;
  logic              refuse;

  assign busy = (busy_cnt_q != '0);
  // a stalled cpu cannot issue, but a bus master could, so refuse then too
  assign idle = !busy && (stall_cnt_q == 3'h0);

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      nvm_addr_reg_q <= '0;
    else if (wr_addr && !busy)
      nvm_addr_reg_q <= pwdata_i[ADDR_W-1:0];
  end

  // a read command (rd_go) loads the byte value register from the array at once
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      nvm_byte_value_reg_q <= `EEBP_RST_BYTE;
    else if (rd_go)
      nvm_byte_value_reg_q <= mem_q[nvm_addr_reg_q];
    else if (wr_data && !busy)
      nvm_byte_value_reg_q <= pwdata_i[7:0];
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      program_mode_field_q <= 2'h0;
    else if (wr_ctrl && !busy)
      program_mode_field_q <= pwdata_i[`EEBP_CTRL_MODE_HI:`EEBP_CTRL_MODE_LO];
  end

  // --------------------------------------------------------------------------
  // master enable window
  // --------------------------------------------------------------------------
  // master enable opens a four-cycle window and then drops by itself
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      mpe_cnt_q <= 3'h0;
    else if (wr_ctrl && pwdata_i[`EEBP_CTRL_MPE_BIT] && !pwdata_i[`EEBP_CTRL_PE_BIT])
      mpe_cnt_q <= `EEBP_MPE_WINDOW;
    else if (prog_go)
      mpe_cnt_q <= 3'h0;
    else if (mpe_cnt_q != 3'h0)
      mpe_cnt_q <= mpe_cnt_q - 3'h1;
  end

  assign pe_req  = wr_ctrl && pwdata_i[`EEBP_CTRL_PE_BIT];
  // mode comes from the same write that sets program enable
  assign prog_go = pe_req && (mpe_cnt_q != 3'h0) && idle &&
                   (pwdata_i[`EEBP_CTRL_MODE_HI:`EEBP_CTRL_MODE_LO] != EEBP_MODE_RSVD);
  assign rd_go   = wr_ctrl && pwdata_i[`EEBP_CTRL_READ_BIT] && !pe_req && idle;
  assign refuse  = (pe_req && !prog_go) ||
                   (wr_ctrl && pwdata_i[`EEBP_CTRL_READ_BIT] && !pe_req && !idle);

  // --------------------------------------------------------------------------
  // programming sequencer
  // --------------------------------------------------------------------------
  eebp_op_t          op_q;
  logic [ADDR_W-1:0] op_addr_q;
  logic [7:0]        op_data_q;
  logic [CNT_W-1:0]  dur;
  eebp_op_t          op_d;
  logic              done;

  always_comb
  begin
    case (eebp_mode_t'(pwdata_i[`EEBP_CTRL_MODE_HI:`EEBP_CTRL_MODE_LO]))
      EEBP_MODE_ATOMIC:
      begin
        op_d = EEBP_OP_ATOMIC;
        dur  = CNT_W'(ATOMIC_CYC);
      end
      EEBP_MODE_ERASE:
      begin
        op_d = EEBP_OP_ERASE;
        dur  = CNT_W'(ERASE_CYC);
      end
      EEBP_MODE_WRITE:
      begin
        op_d = EEBP_OP_WRITE;
        dur  = CNT_W'(WRITE_CYC);
      end
      default:
      begin
        op_d = EEBP_OP_NONE;
        dur  = '0;
      end
    endcase
  end

  // address and byte are frozen at start; later bus writes cannot corrupt them
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      op_q      <= EEBP_OP_NONE;
      op_addr_q <= '0;
      op_data_q <= `EEBP_RST_BYTE;
    end
    else if (prog_go)
    begin
      op_q      <= op_d;
      op_addr_q <= nvm_addr_reg_q;
      op_data_q <= nvm_byte_value_reg_q;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      busy_cnt_q <= '0;
    else if (prog_go)
      busy_cnt_q <= dur;
    else if (busy)
      busy_cnt_q <= busy_cnt_q - CNT_W'(1);
  end

  assign done = (busy_cnt_q == CNT_W'(1));

  // array effect lands at the end of the programming time
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= `EEBP_ERASED_BYTE;
    end
    else if (done)
    begin
      case (op_q)
        EEBP_OP_ATOMIC: mem_q[op_addr_q] <= op_data_q;
        EEBP_OP_ERASE:  mem_q[op_addr_q] <= `EEBP_ERASED_BYTE;
        // bits can only be cleared; an unerased cell ends up garbled
        EEBP_OP_WRITE:  mem_q[op_addr_q] <= mem_q[op_addr_q] & op_data_q;
        default:        mem_q[op_addr_q] <= mem_q[op_addr_q];
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // cpu stall
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      stall_cnt_q <= 3'h0;
    else if (rd_go)
      stall_cnt_q <= `EEBP_READ_STALL;
    else if (prog_go)
      stall_cnt_q <= `EEBP_PROG_STALL;
    else if (stall_cnt_q != 3'h0)
      stall_cnt_q <= stall_cnt_q - 3'h1;
  end

  assign cpu_stall_o = (stall_cnt_q != 3'h0);
  assign busy_o      = busy;

  // --------------------------------------------------------------------------
  // interrupts
  // --------------------------------------------------------------------------
  logic [1:0] irq_stat_q;
  logic [1:0] irq_en_q;
  logic [1:0] irq_evt;

  assign irq_evt = {refuse, done};

  // a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      irq_stat_q <= 2'h0;
    else
      irq_stat_q <= (irq_stat_q & ~(wr_clr ? pwdata_i[1:0] : 2'h0)) | irq_evt;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      irq_en_q <= 2'h0;
    else if (wr_en)
      irq_en_q <= pwdata_i[1:0];
  end

  assign irq_o = |(irq_stat_q & irq_en_q);

  // --------------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------------
  always_comb
  begin
    prdata_o = 32'h0000_0000;
    case (paddr_i)
      `EEBP_OFS_CTRL:
      begin
        prdata_o[`EEBP_CTRL_MODE_HI:`EEBP_CTRL_MODE_LO] = program_mode_field_q;
        prdata_o[`EEBP_CTRL_MPE_BIT] = (mpe_cnt_q != 3'h0);
        prdata_o[`EEBP_CTRL_PE_BIT]  = busy;
      end
      `EEBP_OFS_ADDR:     prdata_o[ADDR_W-1:0] = nvm_addr_reg_q;
      `EEBP_OFS_DATA:     prdata_o[7:0] = nvm_byte_value_reg_q;
      `EEBP_OFS_IRQ_STAT: prdata_o[1:0] = irq_stat_q;
      `EEBP_OFS_IRQ_EN:   prdata_o[1:0] = irq_en_q;
      default:            prdata_o = 32'h0000_0000;
    endcase
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  localparam int CHK_ATOMIC = ATOMIC_CYC;

  chk_read_stall_len: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    rd_go |=> cpu_stall_o [*4] ##1 !cpu_stall_o)
    else $error("read stall not four cycles");

  chk_prog_stall_len: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    prog_go |=> cpu_stall_o [*2] ##1 !cpu_stall_o)
    else $error("programming stall not two cycles");

  chk_atomic_byte: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (done && op_q == EEBP_OP_ATOMIC) |=> mem_q[$past(op_addr_q)] == $past(op_data_q))
    else $error("atomic program left wrong byte");

  chk_erase_byte: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (done && op_q == EEBP_OP_ERASE) |=> mem_q[$past(op_addr_q)] == `EEBP_ERASED_BYTE)
    else $error("erase left byte not blank");

  chk_write_only: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (done && op_q == EEBP_OP_WRITE && mem_q[op_addr_q] == `EEBP_ERASED_BYTE)
    |=> mem_q[$past(op_addr_q)] == $past(op_data_q))
    else $error("write-only onto blank byte wrong");

  chk_busy_bit_held: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (prog_go && op_d == EEBP_OP_ATOMIC) |=> busy_o && busy_cnt_q == CNT_W'(CHK_ATOMIC))
    else $error("busy not raised for full atomic time");

  chk_busy_clears: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    done |=> !busy_o && (prdata_o[`EEBP_CTRL_PE_BIT] == 1'b0 || paddr_i != `EEBP_OFS_CTRL))
    else $error("program enable did not clear");

  chk_no_start_busy: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    busy_o |-> !prog_go && !rd_go && ($stable(mem_q[nvm_addr_reg_q]) || done))
    else $error("access started while busy");

  chk_lone_enable: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (pe_req && mpe_cnt_q == 3'h0) |-> !prog_go ##1 !busy_o || $past(busy_o))
    else $error("program started without master enable");

  chk_mpe_window: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (wr_ctrl && pwdata_i[`EEBP_CTRL_MPE_BIT] && !pe_req) |=> (mpe_cnt_q != 3'h0) [*1]
    ##4 (mpe_cnt_q == 3'h0 || wr_ctrl || $past(wr_ctrl)))
    else $error("master enable window not four cycles");

endmodule : eebp_ctrl
`default_nettype wire

// file: test/eebp_ctrl_test.sv
/*
  Self-checking bench of the byte-programming controller: APB tasks and
  directed sequences with expected values.
  Assumes the rtl/ package and core, with eebp_consts.svh on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "eebp_consts.svh"

module eebp_ctrl_test;
  import eebp_pkg::*;
  // distinct short counts so a mixed-up mode shows as a wrong length
  localparam int ER_N = 4;
  localparam int WR_N = 6;
  localparam int AT_N = 10;

  logic        core_clk;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cpu_stall;
  logic        busy;
  logic        irq;
  int          error_cnt;
  int          num_checks;

  eebp_ctrl #(
    .ERASE_CYC  (ER_N),
    .WRITE_CYC  (WR_N),
    .ATOMIC_CYC (AT_N)
  ) dut (
    .core_clk_i  (core_clk),
    .arst_n_i    (arst_n),
    .psel_i      (psel),
    .penable_i   (penable),
    .pwrite_i    (pwrite),
    .paddr_i     (paddr),
    .pwdata_i    (pwdata),
    .pstrb_i     (4'hf),
    .prdata_o    (prdata),
    .pready_o    (pready),
    .pslverr_o   (pslverr),
    .cpu_stall_o (cpu_stall),
    .busy_o      (busy),
    .irq_o       (irq)
  );

  always #2 core_clk = ~core_clk;

  // --------------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int n;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) chk(32'h0, 32'h1, "no pready");
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    bus(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp,
                    input string what);
    logic [31:0] r;
    logic        e;
    bus(1'b0, a, 32'h0, r, e);
    chk(r & m, exp, what);
  endtask : rd

  // samples just after each edge, so a count is the number of high cycles
  task automatic count(input int span, output int cb, output int cs);
    cb = 0;
    cs = 0;
    #1;
    repeat (span)
    begin
      if (busy === 1'b1) cb++;
      if (cpu_stall === 1'b1) cs++;
      @(posedge core_clk);
      #1;
    end
  endtask : count

  task automatic prog(input logic [1:0] md, input logic [7:0] a, input logic [7:0] d,
                      input int nb, input int ns);
    int cb;
    int cs;
    wr(`EEBP_OFS_ADDR, {24'h0, a});
    if (md != 2'h1) wr(`EEBP_OFS_DATA, {24'h0, d});
    wr(`EEBP_OFS_CTRL, {26'h0, md, 4'h4});
    wr(`EEBP_OFS_CTRL, {26'h0, md, 4'h2});
    count(AT_N + 8, cb, cs);
    chk(cb, nb, "busy length");
    chk(cs, ns, "prog stall");
  endtask : prog

  task automatic rdbyte(input logic [7:0] a, input logic [7:0] exp);
    int cb;
    int cs;
    wr(`EEBP_OFS_ADDR, {24'h0, a});
    wr(`EEBP_OFS_CTRL, 32'h1);
    count(8, cb, cs);
    chk(cs, 4, "read stall");
    rd(`EEBP_OFS_DATA, 32'hff, {24'h0, exp}, "byte value");
  endtask : rdbyte

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // --------------------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    logic        e;
    int          cb;
    int          cs;
    core_clk = 1'b0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(`EEBP_OFS_CTRL, 32'hffffffff, 32'h0, "ctrl reset");
    rd(`EEBP_OFS_ADDR, 32'hffffffff, 32'h0, "addr reset");
    rd(`EEBP_OFS_DATA, 32'hffffffff, 32'h0, "data reset");
    rd(`EEBP_OFS_IRQ_STAT, 32'hffffffff, 32'h0, "stat reset");
    bus(1'b0, 12'h018, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(r, 32'h0, "unmapped read");
    wr(`EEBP_OFS_IRQ_EN, 32'h3);
    rdbyte(8'h09, 8'hff);
    prog(2'h0, 8'h09, 8'h3c, AT_N, 2);
    rdbyte(8'h09, 8'h3c);
    chk({31'h0, irq}, 32'h1, "irq on done");
    wr(`EEBP_OFS_IRQ_CLR, 32'h3);
    rd(`EEBP_OFS_IRQ_STAT, 32'h3, 32'h0, "stat cleared");
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(`EEBP_OFS_IRQ_EN, 32'h0);
    prog(2'h1, 8'h09, 8'h00, ER_N, 2);
    rd(`EEBP_OFS_IRQ_STAT, 32'h1, 32'h1, "done while masked");
    chk({31'h0, irq}, 32'h0, "irq masked");
    rdbyte(8'h09, 8'hff);
    wr(`EEBP_OFS_IRQ_EN, 32'h3);
    // the enable lands at the edge that ends the write; look once it has settled
    #1;
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    wr(`EEBP_OFS_IRQ_CLR, 32'h3);
    prog(2'h2, 8'h09, 8'h5a, WR_N, 2);
    rdbyte(8'h09, 8'h5a);
    // mode three is not a programming mode and must start nothing
    prog(2'h3, 8'h09, 8'h11, 0, 0);
    rdbyte(8'h09, 8'h5a);
    wr(`EEBP_OFS_IRQ_CLR, 32'h3);
    wr(`EEBP_OFS_CTRL, 32'h2);
    count(AT_N, cb, cs);
    chk(cb, 0, "lone enable");
    rd(`EEBP_OFS_IRQ_STAT, 32'h2, 32'h2, "lone refused");
    wr(`EEBP_OFS_CTRL, 32'h4);
    repeat (5) @(posedge core_clk);
    rd(`EEBP_OFS_CTRL, 32'h4, 32'h0, "window closed");
    wr(`EEBP_OFS_CTRL, 32'h2);
    count(AT_N, cb, cs);
    chk(cb, 0, "late enable");
    wr(`EEBP_OFS_IRQ_CLR, 32'h3);
    wr(`EEBP_OFS_DATA, 32'h0f);
    wr(`EEBP_OFS_CTRL, 32'h4);
    wr(`EEBP_OFS_CTRL, 32'h2);
    rd(`EEBP_OFS_CTRL, 32'h2, 32'h2, "enable reads set");
    wr(`EEBP_OFS_ADDR, 32'h03);
    wr(`EEBP_OFS_CTRL, 32'h1);
    count(AT_N, cb, cs);
    rd(`EEBP_OFS_CTRL, 32'h2, 32'h0, "enable self clears");
    rd(`EEBP_OFS_IRQ_STAT, 32'h3, 32'h3, "busy refusal");
    rd(`EEBP_OFS_ADDR, 32'h7f, 32'h09, "addr held");
    rdbyte(8'h09, 8'h0f);
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    close_out();
  end
endmodule : eebp_ctrl_test
`default_nettype wire
